//--- dcc_map.vh
// register offsets, field positions, reset values and timing for the dac code calibration block
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
// register byte addresses (word aligned)
`define DCC_DATA_OFS 8'h00
`define DCC_GAIN_OFS 8'h04
`define DCC_OFFSET_OFS 8'h08
`define DCC_CFG_OFS 8'h0c
`define DCC_STATUS_OFS 8'h10
`define DCC_IRQ_STAT_OFS 8'h14
`define DCC_IRQ_MASK_OFS 8'h18
`define DCC_CODE_OFS 8'h1c
// configuration field positions
`define DCC_CFG_RANGE_BIT 0
`define DCC_CFG_CLR_RANGE_BIT 1
`define DCC_CFG_CLR_BIT 2
`define DCC_CFG_ALARM_RESP_LO 3
`define DCC_CFG_ALARM_RESP_HI 4
`define DCC_CFG_WIDTH 5
// irq status bits
`define DCC_IRQ_ALARM_BIT 0
`define DCC_IRQ_UPDATE_BIT 1
`define DCC_IRQ_WIDTH 2
// alarm response encodings
`define DCC_ALRESP_HOLD 2'h0
`define DCC_ALRESP_ZERO 2'h1
`define DCC_ALRESP_CLEAR 2'h2
`define DCC_ALRESP_FULL 2'h3
// reset values
`define DCC_GAIN_RST 16'h8000
`define DCC_DATA_RST 16'h0000
`define DCC_OFFSET_RST 16'h0000
`define DCC_CFG_RST 5'h00
`define DCC_CLR_CODE_RST 16'h0000
// internal clock synchronisation latency, in tenths of cycles (2.5 cycles)
`define DCC_SYNC_LAT_TENTHS 25
`define DCC_SYNC_CYCLES ((`DCC_SYNC_LAT_TENTHS) / 10)
// the same whole-cycle count, sized for the two-bit latency counter
`define DCC_SYNC_CNT_INIT 2'h2
`endif

//--- dcc_top.v
// dac code calibration: data, gain and offset registers feeding a clamped string dac code
`timescale 1ns/1ps
`default_nettype none
`include "dcc_map.vh"
module dcc_top #(
  parameter NARROW = 0 // 1 selects the 14-bit variant
) (
  input wire clk_in, // 100 mhz clock
  input wire reset_in, // synchronous reset, active high
  input wire [7:0] avs_address_in, // byte address
  input wire avs_read_in, // read request
  input wire avs_write_in, // write request
  input wire [31:0] avs_writedata_in, // write data
  input wire [3:0] avs_byteenable_in, // byte lanes
  output wire [31:0] avs_readdata_out, // read data
  output wire avs_waitrequest_out, // stall
  input wire output_supply_high_in, // output supply is the high level (async pin)
  input wire output_supply_ok_in, // output supply within window (async pin)
  input wire core_supply_ok_in, // core supply within window (async pin)
  input wire clear_pin_in, // external clear state request (async pin)
  output wire [15:0] dac_code_out, // code to the resistor string
  output wire [1:0] range_sel_out, // {supply high, range bit}
  output wire alarm_out, // supply alarm level
  output wire irq_out // interrupt, level
);

  // widths: code width is 16 or 14, registers always 16 left justified
  localparam [15:0] KEEP_MASK = NARROW ? 16'hfffc : 16'hffff;
  localparam [15:0] CODE_MAX = NARROW ? 16'hfffc : 16'hffff;
  // the offset always loses its two lsbs, whatever the variant
  localparam [15:0] OFS_MASK = 16'hfffc;
  // pin synchroniser width and its reset pattern
  // reset pattern claims good supplies and no clear, so no alarm follows reset
  localparam SYNC_BITS = 4;
  localparam [3:0] SYNC_RST = 4'h6;

  // software registers
  reg [15:0] data_r;
  reg [15:0] gain_r;
  reg [15:0] offset_r;
  reg [`DCC_CFG_WIDTH-1:0] cfg_r;
  reg [15:0] clr_code_r;
  reg [`DCC_IRQ_WIDTH-1:0] irq_stat_r;
  reg [`DCC_IRQ_WIDTH-1:0] irq_mask_r;

  // bus side flops
  reg [31:0] rdata_r;
  reg wait_r;

  // calibration pipeline and output flops
  reg [15:0] cal_r;
  reg cal_vld_r;
  reg [1:0] sync_cnt_r;
  reg [15:0] dac_r;
  reg [15:0] dac_nxt;
  reg [1:0] range_r;
  reg alarm_r;
  reg irq_r;

  // read multiplexer output
  reg [31:0] rdata_nxt;

  // raw and synchronised pin levels
  wire [SYNC_BITS-1:0] pin_raw;
  wire [SYNC_BITS-1:0] pin_sync;

  // pins gathered so one generate loop treats them alike
  assign pin_raw = {clear_pin_in, core_supply_ok_in, output_supply_ok_in, output_supply_high_in};

  // two flops per pin; only the second stage is read by any logic
  // the supply pins are slow levels, so a skew of one cycle between bits is harmless
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_BITS; gi = gi + 1)
    begin : g_sync
      reg s1_r;
      reg s2_r;
      always @(posedge clk_in)
      begin
        if (reset_in)
        begin
          s1_r <= SYNC_RST[gi];
          s2_r <= SYNC_RST[gi];
        end
        else
        begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
        end
      end
      assign pin_sync[gi] = s2_r;
    end
  endgenerate

  // synchronised pin meanings
  wire sup_high = pin_sync[0];
  wire sup_ok = pin_sync[1] & pin_sync[2];
  // software clear and pin clear are or'ed; either one holds the clear state
  wire clear_state = cfg_r[`DCC_CFG_CLR_BIT] | pin_sync[3];
  wire alarm_now = ~sup_ok;
  // latency counter still running, shown as busy in the status word
  wire upd_busy = sync_cnt_r != 2'h0;

  // bus decode: the first request cycle loads read data, the second acknowledges
  // so read data already stands in the cycle where waitrequest is low
  wire req = (avs_read_in | avs_write_in) & ~wait_r;
  wire wr = avs_write_in & wait_r;
  wire sel_data = avs_address_in == `DCC_DATA_OFS;
  wire sel_gain = avs_address_in == `DCC_GAIN_OFS;
  wire sel_off = avs_address_in == `DCC_OFFSET_OFS;
  wire sel_cfg = avs_address_in == `DCC_CFG_OFS;
  wire sel_istat = avs_address_in == `DCC_IRQ_STAT_OFS;
  wire sel_imask = avs_address_in == `DCC_IRQ_MASK_OFS;
  wire [15:0] wd16 = avs_writedata_in[15:0];
  wire [1:0] be16 = avs_byteenable_in[1:0];

  // byte-lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] be;
    begin
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // calibration inputs after the variant masks
  // all three stay left justified, so one arithmetic path serves both variants
  wire [15:0] d_eff = data_r & KEEP_MASK;
  wire [15:0] g_eff = gain_r & KEEP_MASK;
  wire [15:0] o_eff = offset_r & OFS_MASK;

  // data * (1/2 + gain/2^16) is (data*2^15 + data*gain) / 2^16
  // data times gain register, full 32-bit product
  wire [31:0] dg_prod = d_eff * g_eff;
  // data times one half, on the same 2^16 scale
  wire [31:0] half_prod = {1'b0, d_eff, 15'h0000};
  // sum of both terms; the extra top bit keeps the overflow above 1.0
  wire [32:0] prod = {1'b0, dg_prod} + {1'b0, half_prod};
  // drop the sixteen fraction bits with no rounding term
  // a rounded product could come out one lsb higher; software must allow for it
  wire [16:0] gained = prod[32:16];
  // signed sum of gained data and offset, with guard bits for both overflows
  wire signed [18:0] sum = $signed({2'b00, gained})
                           + $signed({{3{o_eff[15]}}, o_eff});
  reg [15:0] clamped;
  always @*
  begin
    // saturate rather than wrap on gain or offset overflow
    if (sum[18])
      clamped = 16'h0000;
    else if (sum[17:16] != 2'b00 || sum[15:0] > CODE_MAX)
      clamped = CODE_MAX;
    else
      clamped = sum[15:0] & KEEP_MASK;
  end

  // register file
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      data_r <= `DCC_DATA_RST;
      gain_r <= `DCC_GAIN_RST;
      offset_r <= `DCC_OFFSET_RST;
      cfg_r <= `DCC_CFG_RST;
      clr_code_r <= `DCC_CLR_CODE_RST;
      irq_mask_r <= {`DCC_IRQ_WIDTH{1'b0}};
      rdata_r <= 32'h00000000;
      wait_r <= 1'b0;
      cal_vld_r <= 1'b0;
    end
    else
    begin
      wait_r <= (avs_read_in | avs_write_in) & ~wait_r;
      cal_vld_r <= wr & sel_data; // recompute only on a data write
      if (wr && sel_data)
        data_r <= merge16(data_r, wd16, be16);
      if (wr && sel_gain)
        gain_r <= merge16(gain_r, wd16, be16);
      if (wr && sel_off)
        offset_r <= merge16(offset_r, wd16, be16);
      if (wr && sel_cfg && be16[0])
        cfg_r <= wd16[`DCC_CFG_WIDTH-1:0];
      if (wr && sel_cfg)
        clr_code_r <= {be16[1] ? wd16[15:8] : clr_code_r[15:8], 8'h00} & KEEP_MASK;
      if (wr && sel_imask && be16[0])
        irq_mask_r <= wd16[`DCC_IRQ_WIDTH-1:0];
      // read data loads one cycle ahead of the acknowledge
      // and then stands until the next read
      if (req && avs_read_in)
        rdata_r <= rdata_nxt;
    end
  end

  // read multiplexer; unmapped offsets read as zero
  // status word: clear state, supply high, alarm, update busy
  always @*
  begin
    rdata_nxt = 32'h00000000;
    case (avs_address_in)
      `DCC_DATA_OFS:
        rdata_nxt = {16'h0000, data_r};
      `DCC_GAIN_OFS:
        rdata_nxt = {16'h0000, gain_r};
      `DCC_OFFSET_OFS:
        rdata_nxt = {16'h0000, offset_r};
      `DCC_CFG_OFS:
        rdata_nxt = {16'h0000, clr_code_r[15:8], 3'b000, cfg_r};
      `DCC_STATUS_OFS:
        rdata_nxt = {28'h0000000, clear_state, sup_high, alarm_r, upd_busy};
      `DCC_IRQ_STAT_OFS:
        rdata_nxt = {30'h00000000, irq_stat_r};
      `DCC_IRQ_MASK_OFS:
        rdata_nxt = {30'h00000000, irq_mask_r};
      `DCC_CODE_OFS:
        rdata_nxt = {16'h0000, dac_r};
      default:
        rdata_nxt = 32'h00000000;
    endcase
  end

  // capture calibrated code, then hold through the sync delay
  // gain or offset edits alone never start this path
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cal_r <= 16'h0000;
      sync_cnt_r <= 2'h0;
    end
    else if (cal_vld_r)
    begin
      cal_r <= clamped;
      sync_cnt_r <= `DCC_SYNC_CNT_INIT;
    end
    else if (sync_cnt_r != 2'h0)
      sync_cnt_r <= sync_cnt_r - 2'h1;
  end

  // next dac code: alarm beats clear state, clear state beats data
  // leaving clear or alarm keeps the last code until the next data write
  always @*
  begin
    dac_nxt = dac_r;
    if (alarm_now)
    begin
      case (cfg_r[`DCC_CFG_ALARM_RESP_HI:`DCC_CFG_ALARM_RESP_LO])
        `DCC_ALRESP_ZERO:
          dac_nxt = 16'h0000;
        `DCC_ALRESP_CLEAR:
          dac_nxt = clr_code_r;
        `DCC_ALRESP_FULL:
          dac_nxt = CODE_MAX;
        default:
          dac_nxt = dac_r; // hold keeps the last good code
      endcase
    end
    else if (clear_state)
      dac_nxt = clr_code_r;
    else if (sync_cnt_r == 2'h1)
      dac_nxt = cal_r; // lands two cycles after capture
  end

  // dac code, range and alarm output flops
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      dac_r <= 16'h0000;
      range_r <= 2'h0;
      alarm_r <= 1'b0;
    end
    else
    begin
      alarm_r <= alarm_now;
      // range bit swaps to the clear range while clearing
      range_r <= {sup_high, clear_state ? cfg_r[`DCC_CFG_CLR_RANGE_BIT]
                                        : cfg_r[`DCC_CFG_RANGE_BIT]};
      dac_r <= dac_nxt;
    end
  end

  // sticky interrupt status; set beats write-one-clear
  // so an event in the clearing cycle is never lost
  wire [`DCC_IRQ_WIDTH-1:0] ev = {sync_cnt_r == 2'h1, alarm_now & ~alarm_r};
  wire [`DCC_IRQ_WIDTH-1:0] w1c = (wr && sel_istat && be16[0]) ?
                                  wd16[`DCC_IRQ_WIDTH-1:0] : {`DCC_IRQ_WIDTH{1'b0}};
  wire [`DCC_IRQ_WIDTH-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | ev;
  // the interrupt flop follows the next status, so it never lags a cycle behind it
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      irq_stat_r <= {`DCC_IRQ_WIDTH{1'b0}};
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // every output comes straight from a flop, except waitrequest, which is the inverted wait flop
  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = ~wait_r;
  assign dac_code_out = dac_r;
  assign range_sel_out = range_r;
  assign alarm_out = alarm_r;
  assign irq_out = irq_r;

endmodule
`default_nettype wire

//--- dcc_top_chk.sv
// port-level assertions for the dac code calibration block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_chk (
  input wire logic clk_in, // clock
  input wire logic reset_in, // sync reset
  input wire logic [7:0] avs_address_in, // address
  input wire logic avs_read_in, // read
  input wire logic avs_write_in, // write
  input wire logic [31:0] avs_readdata_out, // read data
  input wire logic avs_waitrequest_out, // stall
  input wire logic output_supply_ok_in, // supply ok
  input wire logic core_supply_ok_in, // core ok
  input wire logic [15:0] dac_code_out, // code
  input wire logic [1:0] range_sel_out, // range
  input wire logic alarm_out, // alarm
  input wire logic irq_out // interrupt
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // pending request, and a calibration write being taken
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_cal_wr;
    avs_write_in && !avs_waitrequest_out && avs_address_in inside {8'h04, 8'h08};
  endsequence
  // bus handshake: one wait cycle, one ack cycle, ack only for a request
  property p_ack_next; s_req |=> !avs_waitrequest_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rd_hold; $changed(avs_readdata_out) |-> $past(avs_read_in); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // calibration changes wait for the next data write
  property p_cal_quiet; s_cal_wr |=> $stable(dac_code_out) [*4]; endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("code moved on cal write");
  // supply window alarm, allowing for the pin synchroniser
  property p_alarm_set; !output_supply_ok_in [*6] |-> alarm_out; endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm missing");
  property p_alarm_clr; (output_supply_ok_in && core_supply_ok_in) [*6] |-> !alarm_out; endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm stuck");
  property p_rst;
    disable iff (1'b0) reset_in |=> avs_waitrequest_out && dac_code_out == 16'h0000
      && !alarm_out && !irq_out && range_sel_out == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind dcc_top dcc_top_chk u_chk (.*);
`default_nettype wire

//--- tb_dcc_top.sv
// self-checking bench for the dac code calibration block
`timescale 1ns/1ps
`default_nettype none
module tb_dcc_top;
  logic clk_in = 0, reset_in = 1, avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out;
  logic output_supply_high_in = 0, output_supply_ok_in = 1, core_supply_ok_in = 1;
  logic clear_pin_in = 0, alarm_out, irq_out;
  logic [7:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out;
  logic [15:0] dac_code_out, d, g, o;
  logic [1:0] range_sel_out;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  dcc_top dut (.*, .avs_byteenable_in(4'hf));
  always #5 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access; idle edge after release so the next one never doubles a strobe
  task automatic bus(input logic [7:0] a, input logic wr, input logic [15:0] wd);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {16'h0000, wd};
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0 && ++n < 50);
    avs_read_in <= 0;
    avs_write_in <= 0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 0, 16'h0000);
  endtask
  // read results are checked where they appear
  always @(posedge clk_in)
    if (avs_read_in && avs_waitrequest_out === 1'b0)
      chk(avs_readdata_out, exp_q.pop_front());
  // truncated gain product plus offset with its two lsbs dropped, clamped
  function automatic logic [31:0] calc(input logic [15:0] dd, gg, oo);
    longint v;
    v = (longint'(dd) * (32768 + gg)) >>> 16;
    v = v + longint'($signed({oo[15:2], 2'b00}));
    if (v < 0)
      v = 0;
    if (v > 65535)
      v = 65535;
    return v[31:0];
  endfunction
  task automatic rng(input logic [15:0] cfg, input logic pin, input logic [1:0] e);
    clear_pin_in <= pin;
    bus(8'h0c, 1, cfg);
    repeat (5) @(posedge clk_in);
    chk(range_sel_out, e);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #300us;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'hd6486ed0));
    repeat (20) @(posedge clk_in);
    reset_in <= 0;
    rd(8'h04, 32'h8000);
    rd(8'h00, 0);
    rd(8'h08, 0);
    rd(8'h40, 0);
    bus(8'h18, 1, 16'h0002);
    for (int i = 0; i < 24; i++)
    begin
      {d, g, o} = {$urandom, $urandom};
      if (i == 0)
        {d, g, o} = 48'hffff_ffff_7ffc;
      if (i == 1)
        {d, g, o} = 48'h0000_0000_8003;
      if (i == 2)
        {d, g, o} = 48'hffff_0000_0003;
      bus(8'h04, 1, g);
      bus(8'h08, 1, o);
      bus(8'h14, 1, 16'h0002);
      chk(irq_out, 0);
      bus(8'h00, 1, d);
      repeat (6) @(posedge clk_in);
      chk(irq_out, 1);
      rd(8'h1c, calc(d, g, o));
      bus(8'h04, 1, ~g);
      bus(8'h08, 1, ~o);
      rd(8'h1c, calc(d, g, o));
    end
    bus(8'h14, 1, 16'h0003);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 0);
    output_supply_high_in <= 1;
    rng(16'h0001, 0, 2'b11);
    rng(16'h0005, 0, 2'b10);
    rd(8'h1c, 0);
    rng(16'h0002, 1, 2'b11);
    rng(16'h0000, 0, 2'b10);
    bus(8'h14, 1, 16'h0003);
    bus(8'h18, 1, 16'h0000);
    output_supply_ok_in <= 0;
    repeat (8) @(posedge clk_in);
    chk(alarm_out, 1);
    chk(irq_out, 0);
    rd(8'h14, 1);
    bus(8'h18, 1, 16'h0001);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 1);
    {output_supply_ok_in, core_supply_ok_in} <= 2'b10;
    repeat (8) @(posedge clk_in);
    chk(alarm_out, 1);
    core_supply_ok_in <= 1;
    repeat (8) @(posedge clk_in);
    chk(alarm_out, 0);
    bus(8'h14, 1, 16'h0003);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
